// ### hw/ped_dispatch.sv
/*
 Event and fault dispatcher: maps wake, sleep, supply, clock and recovery
 events onto state machine triggers, shutdown actions and W1C flags.
 Assumes supply and clock fault detectors give synchronous levels and that
 rstn_in is released only after the analog main supply is valid.
*/
`timescale 1ns/1ps
module ped_dispatch (
	input  wire logic                        ref_clk_in,
	input  wire logic                        rstn_in,
	input  wire logic                        internal_regulator_fault_in,
	input  wire logic                        main_clk_fault_in,
	input  wire logic                        analog_main_supply_uvlo_in,
	input  wire logic                        first_supply_detect_in,
	input  wire logic                        recovery_event_in,
	input  wire logic [ped_pkg::RECOV_W-1:0] recovery_count_limit_in,
	input  wire logic [1:0]                  startup_target_state_in,
	input  wire logic                        clk_detector_enable_in,
	input  wire logic                        clk_detector_missing_in,
	input  wire logic                        if_addr_error_in,
	input  wire logic                        primary_if_crc_enable_in,
	input  wire logic                        secondary_if_crc_enable_in,
	input  wire ped_pkg::ped_nvm_cfg_t       nvm_cfg_in,
	input  wire logic                        wake_to_active_in,
	input  wire logic                        wake_to_mcu_only_in,
	input  wire logic                        sleep_ctrl_a_n_in,
	input  wire logic                        sleep_ctrl_b_n_in,
	input  wire logic                        sleep_ctrl_a_bit_in,
	input  wire logic                        sleep_ctrl_b_bit_in,
	input  wire logic                        sleep_ctrl_a_irq_mask_in,
	input  wire logic                        sleep_ctrl_b_irq_mask_in,
	input  wire logic [1:0]                  pin_rise_irq_mask_in,
	input  wire logic [1:0]                  pin_fall_irq_mask_in,
	input  wire logic                        first_supply_irq_mask_in,
	input  wire logic                        clk_missing_irq_mask_in,
	input  wire logic                        addr_err_irq_mask_in,
	input  wire ped_pkg::ped_irq_t           irq_clear_in,
	output ped_pkg::ped_irq_t                irq_flag_out,
	output logic                             irq_out,
	output ped_pkg::ped_trigger_t            trigger_out,
	output logic [1:0]                       startup_trigger_out,
	output ped_pkg::ped_sleep_sel_t          sleep_sel_out,
	output ped_pkg::ped_shutdown_t           shutdown_out,
	output logic                             logic_reset_out,
	output logic [ped_pkg::RECOV_W-1:0]      recovery_count_out,
	output logic [ped_pkg::NUM_PINS-1:0]     pin_live_level_out
);

	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edge detection

	logic [ped_pkg::NUM_PINS-1:0] pins_sync;
	logic [ped_pkg::NUM_PINS-1:0] pins_prev;
	logic [1:0]                   wake_rise;
	logic [1:0]                   wake_fall;
	logic [1:0]                   wake_hit;
	logic [1:0]                   wake_irq;
	logic [ped_pkg::SYNC_STAGES-1:0] sync_fill;
	logic                         pins_valid;

	// Sleep pins idle high but the synchroniser resets low: hold them awake
	// until the synchroniser has filled, so no false sleep follows reset
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			sync_fill <= '0;
		else
			sync_fill <= {sync_fill[ped_pkg::SYNC_STAGES-2:0], 1'b1};
	end

	assign pins_valid = sync_fill[ped_pkg::SYNC_STAGES-1];

	ped_pin_sync #(
		.WIDTH(ped_pkg::NUM_PINS)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.rstn_in   (rstn_in),
		.async_in  ({sleep_ctrl_b_n_in, sleep_ctrl_a_n_in,
		             wake_to_mcu_only_in, wake_to_active_in}),
		.sync_out  (pins_sync)
	);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pins_prev          <= '0;
			pin_live_level_out <= '0;
		end else begin
			pins_prev          <= pins_sync;
			pin_live_level_out <= pins_sync;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_wake
			assign wake_rise[gi] = pins_sync[gi] & ~pins_prev[gi];
			assign wake_fall[gi] = ~pins_sync[gi] & pins_prev[gi];
			assign wake_hit[gi]  = wake_rise[gi] | wake_fall[gi];
			assign wake_irq[gi]  = (wake_rise[gi] & ~pin_rise_irq_mask_in[gi])
			                     | (wake_fall[gi] & ~pin_fall_irq_mask_in[gi]);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Fault classification

	logic hard_fault;
	logic clk_event;
	logic addr_event;
	logic crc_active;
	logic limit_hit;

	assign hard_fault = internal_regulator_fault_in
	                  | analog_main_supply_uvlo_in;
	assign clk_event  = clk_detector_enable_in & clk_detector_missing_in;
	assign crc_active = primary_if_crc_enable_in
	                  & secondary_if_crc_enable_in;
	assign addr_event = if_addr_error_in & crc_active;
	assign limit_hit  = (recovery_count_limit_in != ped_pkg::RECOV_LIM_OFF)
	                  & (recovery_count_out > recovery_count_limit_in);

	//////////////////////////////////////////////////////////////////////////
	// Lock state: clock fault and recovery exhaustion need a power cycle

	ped_pkg::ped_state_t state;
	ped_pkg::ped_state_t next_state;
	logic                clk_lock_fault;
	logic                limit_fault;
	logic                clk_locked;

	// A clock fault holds until power cycle even if the clock recovers
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			clk_locked <= 1'b0;
		else if (main_clk_fault_in)
			clk_locked <= 1'b1;
	end

	assign clk_lock_fault = main_clk_fault_in | clk_locked;
	assign limit_fault    = limit_hit
	                      & (nvm_cfg_in.recov_limit != ped_pkg::ACT_NONE);

	always_comb begin
		next_state = state;
		case (state)
			ped_pkg::PED_ST_POR: begin
				if (clk_lock_fault || limit_fault)
					next_state = ped_pkg::PED_ST_LOCKED;
				else
					next_state = ped_pkg::PED_ST_RUN;
			end
			ped_pkg::PED_ST_RUN: begin
				if (clk_lock_fault || limit_fault)
					next_state = ped_pkg::PED_ST_LOCKED;
			end
			ped_pkg::PED_ST_LOCKED: next_state = ped_pkg::PED_ST_LOCKED;
			default: next_state = ped_pkg::PED_ST_POR;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			state <= ped_pkg::PED_ST_POR;
		else if (hard_fault)
			state <= ped_pkg::PED_ST_POR;
		else
			state <= next_state;
	end

	//////////////////////////////////////////////////////////////////////////
	// Recovery counter

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			recovery_count_out <= ped_pkg::RECOV_RESET;
		else if (recovery_event_in
		         && recovery_count_out != ped_pkg::RECOV_MAX)
			recovery_count_out <= recovery_count_out + 4'h1;
	end

	//////////////////////////////////////////////////////////////////////////
	// Triggers, sleep selection and shutdown actions

	logic                  sleep_a;
	logic                  sleep_b;
	logic                  first_seen;
	logic                  limit_seq;
	ped_pkg::ped_trigger_t next_trigger;
	ped_pkg::ped_shutdown_t next_shutdown;

	assign sleep_a = (pins_sync[ped_pkg::PIN_SLEEP_A] | sleep_ctrl_a_bit_in)
	               | sleep_ctrl_a_irq_mask_in | ~pins_valid;
	assign sleep_b = (pins_sync[ped_pkg::PIN_SLEEP_B] | sleep_ctrl_b_bit_in)
	               | sleep_ctrl_b_irq_mask_in | ~pins_valid;
	assign limit_seq = (nvm_cfg_in.recov_limit == ped_pkg::ACT_ORDERLY);

	always_comb begin
		next_trigger  = ped_pkg::PED_TRG_NONE;
		next_shutdown = '0;
		if (hard_fault || clk_lock_fault) begin
			next_trigger  = ped_pkg::PED_TRG_IMMEDIATE;
			next_shutdown = '{regulators_off: 1'b1, pulldowns_on: 1'b1,
			                  gpio_low: 1'b1, sequenced: 1'b0};
		end else if (state == ped_pkg::PED_ST_LOCKED) begin
			next_trigger  = limit_seq ? ped_pkg::PED_TRG_ORDERLY
			                          : ped_pkg::PED_TRG_IMMEDIATE;
			next_shutdown = '{regulators_off: 1'b1, pulldowns_on: ~limit_seq,
			                  gpio_low: 1'b1, sequenced: limit_seq};
		end else if (first_supply_detect_in && !first_seen) begin
			next_trigger = ped_pkg::PED_TRG_STARTUP;
		end else if (wake_hit[ped_pkg::PIN_WAKE_A]) begin
			next_trigger = ped_pkg::PED_TRG_ACTIVE;
		end else if (wake_hit[ped_pkg::PIN_WAKE_B]) begin
			next_trigger = ped_pkg::PED_TRG_MCU_ONLY;
		end else if (!(sleep_a && sleep_b)) begin
			next_trigger = ped_pkg::PED_TRG_SLEEP;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			trigger_out     <= ped_pkg::PED_TRG_NONE;
			shutdown_out    <= '{default: 1'b1};
			logic_reset_out <= 1'b1;
		end else begin
			trigger_out     <= next_trigger;
			shutdown_out    <= next_shutdown;
			logic_reset_out <= hard_fault | clk_lock_fault;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in)
			sleep_sel_out <= ped_pkg::PED_SLP_ACTIVE;
		else if (sleep_a && sleep_b)
			sleep_sel_out <= ped_pkg::PED_SLP_ACTIVE;
		else if (sleep_a)
			sleep_sel_out <= ped_pkg::PED_SLP_MCU_ONLY;
		else
			sleep_sel_out <= ped_pkg::PED_SLP_RETENTION;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			first_seen          <= 1'b0;
			startup_trigger_out <= 2'h0;
		end else if (first_supply_detect_in && !first_seen) begin
			first_seen          <= 1'b1;
			startup_trigger_out <= startup_target_state_in;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Sticky flags: set wins over write-one clear

	ped_pkg::ped_irq_t set_ev;
	ped_pkg::ped_irq_t next_flag;

	assign set_ev.first_supply = first_supply_detect_in & ~first_seen;
	assign set_ev.pin          = |wake_irq;
	assign set_ev.clk_missing  = clk_event
	                           & (nvm_cfg_in.clk_missing != ped_pkg::ACT_NONE);
	assign set_ev.addr_err     = addr_event;
	assign next_flag = set_ev | (irq_flag_out & ~irq_clear_in);

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_flag_out <= '0;
			irq_out      <= 1'b0;
		end else begin
			irq_flag_out <= next_flag;
			irq_out      <= (next_flag.first_supply & ~first_supply_irq_mask_in)
			              | next_flag.pin
			              | (next_flag.clk_missing & ~clk_missing_irq_mask_in)
			              | (next_flag.addr_err & ~addr_err_irq_mask_in);
		end
	end

endmodule : ped_dispatch

// ### hw/ped_pkg.sv
/*
 Package for the power event and fault dispatcher: constants, enumerations
 and carrier structs shared by the top module and its pin synchroniser.
 Assumes a single 10 MHz clock domain and an active-low async reset.
*/
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package ped_pkg;

	localparam int          RECOV_W        = 4;
	localparam logic [3:0]  RECOV_MAX      = 4'hF;
	localparam logic [3:0]  RECOV_RESET    = 4'h0;
	localparam logic [3:0]  RECOV_LIM_OFF  = 4'h0;
	localparam int          SYNC_STAGES    = 2;
	localparam int          NUM_PINS       = 4;
	localparam int          PIN_WAKE_A     = 0;
	localparam int          PIN_WAKE_B     = 1;
	localparam int          PIN_SLEEP_A    = 2;
	localparam int          PIN_SLEEP_B    = 3;
	localparam logic [1:0]  ACT_IMMEDIATE  = 2'h0;
	localparam logic [1:0]  ACT_ORDERLY    = 2'h1;
	localparam logic [1:0]  ACT_IRQ_ONLY   = 2'h2;
	localparam logic [1:0]  ACT_NONE       = 2'h3;

	typedef enum logic [2:0] {
		PED_TRG_NONE,
		PED_TRG_STARTUP,
		PED_TRG_ACTIVE,
		PED_TRG_MCU_ONLY,
		PED_TRG_SLEEP,
		PED_TRG_ORDERLY,
		PED_TRG_IMMEDIATE
	} ped_trigger_t;

	typedef enum logic [1:0] {
		PED_SLP_ACTIVE,
		PED_SLP_MCU_ONLY,
		PED_SLP_RETENTION
	} ped_sleep_sel_t;

	typedef enum {
		PED_ST_POR,
		PED_ST_RUN,
		PED_ST_LOCKED
	} ped_state_t;

	// Per-event action selection loaded from non-volatile settings
	typedef struct packed {
		logic [1:0] recov_limit;
		logic [1:0] clk_missing;
	} ped_nvm_cfg_t;

	typedef struct packed {
		logic regulators_off;
		logic pulldowns_on;
		logic gpio_low;
		logic sequenced;
	} ped_shutdown_t;

	typedef struct packed {
		logic first_supply;
		logic pin;
		logic clk_missing;
		logic addr_err;
	} ped_irq_t;

endpackage : ped_pkg

// ### hw/ped_pin_sync.sv
/*
 Two-flop synchroniser for the asynchronous wake and sleep pins.
 Assumes pins are asynchronous to ref_clk_in.
*/
`timescale 1ns/1ps
module ped_pin_sync #(
	parameter int WIDTH = ped_pkg::NUM_PINS
) (
	input  wire logic             ref_clk_in,
	input  wire logic             rstn_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : ped_pin_sync

// ### test/ped_dispatch_assertions.sv
/*
 Checker for ped_dispatch: concurrent properties on the top ports.
 Assumes it is bound to every ped_dispatch instance, one clock domain.
*/
`timescale 1ns/1ps
module ped_dispatch_assertions (
	input wire logic              ref_clk_in,
	input wire logic              rstn_in,
	input wire logic              internal_regulator_fault_in,
	input wire logic              main_clk_fault_in,
	input wire logic              analog_main_supply_uvlo_in,
	input wire logic              first_supply_detect_in,
	input wire logic              recovery_event_in,
	input wire logic [3:0]        recovery_count_limit_in,
	input wire logic              clk_detector_enable_in,
	input wire logic              clk_detector_missing_in,
	input wire logic              if_addr_error_in,
	input wire logic              primary_if_crc_enable_in,
	input wire logic              secondary_if_crc_enable_in,
	input wire ped_pkg::ped_nvm_cfg_t nvm_cfg_in,
	input wire ped_pkg::ped_irq_t irq_clear_in,
	input wire ped_pkg::ped_irq_t irq_flag_out,
	input wire ped_pkg::ped_shutdown_t shutdown_out,
	input wire logic              logic_reset_out,
	input wire logic [3:0]        recovery_count_out
);
	logic calm;
	assign calm = !internal_regulator_fault_in && !main_clk_fault_in &&
		!analog_main_supply_uvlo_in && !logic_reset_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_over;
		recovery_event_in && calm && recovery_count_limit_in != 4'h0 &&
		recovery_count_limit_in <= recovery_count_out &&
		recovery_count_out != 4'hF &&
		nvm_cfg_in.recov_limit == ped_pkg::ACT_ORDERLY;
	endsequence
	sequence s_orderly_off;
		shutdown_out == 4'hB;
	endsequence
	a_ldo_reset: assert property (
		internal_regulator_fault_in || main_clk_fault_in |=>
		logic_reset_out && shutdown_out[3:1] == 3'h7)
		else $error("supply or clock fault without reset");
	a_uvlo_reset: assert property (
		analog_main_supply_uvlo_in |=>
		logic_reset_out && shutdown_out[3:1] == 3'h7)
		else $error("undervoltage without reset");
	a_limit_lock: assert property (
		s_over |-> ##3 s_orderly_off)
		else $error("limit exceeded without orderly shutdown");
	a_limit_off: assert property (
		(recovery_count_limit_in == 4'h0 && shutdown_out == 4'h0 && calm &&
		nvm_cfg_in.clk_missing != ped_pkg::ACT_ORDERLY)[*4] |=>
		shutdown_out != 4'hB)
		else $error("zero limit still shut down");
	a_count_step: assert property (
		recovery_event_in && calm && recovery_count_out != 4'hF |=>
		recovery_count_out == $past(recovery_count_out) + 4'h1)
		else $error("recovery count did not step");
	a_count_hold: assert property (
		recovery_count_out == 4'hF && calm |=> recovery_count_out == 4'hF)
		else $error("recovery count wrapped");
	a_fsd_source: assert property (
		$rose(irq_flag_out.first_supply) |-> $past(first_supply_detect_in))
		else $error("first supply flag without detection");
	a_fsd_clear: assert property (
		irq_clear_in.first_supply && !first_supply_detect_in |=>
		!irq_flag_out.first_supply)
		else $error("first supply flag not cleared");
	a_clk_flag: assert property (
		clk_detector_enable_in && clk_detector_missing_in && calm &&
		nvm_cfg_in.clk_missing != ped_pkg::ACT_NONE |=>
		irq_flag_out.clk_missing)
		else $error("missing clock flag not set");
	a_addr_gate: assert property (
		$rose(irq_flag_out.addr_err) |-> $past(if_addr_error_in) &&
		$past(primary_if_crc_enable_in) && $past(secondary_if_crc_enable_in))
		else $error("address error without both crc enables");
endmodule : ped_dispatch_assertions
bind ped_dispatch ped_dispatch_assertions ped_dispatch_assertions_i (.*);

// ### test/ped_host_model.sv
/*
 Host model: writes one to each serviced flag that it sees set.
 Assumes svc_in selects which flags the host services.
*/
`timescale 1ns/1ps
module ped_host_model (
	input  wire logic              ref_clk_in,
	input  wire logic              rstn_in,
	input  wire ped_pkg::ped_irq_t flag_in,
	input  wire ped_pkg::ped_irq_t svc_in,
	output ped_pkg::ped_irq_t      clear_out
);
	always_ff @(posedge ref_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clear_out <= '0;
		end else begin
			clear_out <= (clear_out == '0) ? (flag_in & svc_in) : '0;
		end
	end
endmodule : ped_host_model

// ### test/ped_dispatch_test.sv
/*
 Testbench for ped_dispatch with a host model clearing flags.
 Assumes a 10 MHz clock and inputs driven 10 ns after each rising edge.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module ped_dispatch_test;
	logic ref_clk_in, rstn_in, internal_regulator_fault_in, main_clk_fault_in;
	logic analog_main_supply_uvlo_in, first_supply_detect_in, seen;
	logic recovery_event_in, clk_detector_enable_in, clk_detector_missing_in;
	logic if_addr_error_in, primary_if_crc_enable_in;
	logic secondary_if_crc_enable_in, wake_to_active_in, wake_to_mcu_only_in;
	logic sleep_ctrl_a_n_in, sleep_ctrl_b_n_in, sleep_ctrl_a_bit_in;
	logic sleep_ctrl_b_bit_in, sleep_ctrl_a_irq_mask_in, irq_out;
	logic sleep_ctrl_b_irq_mask_in, first_supply_irq_mask_in;
	logic clk_missing_irq_mask_in, addr_err_irq_mask_in, logic_reset_out;
	logic [3:0] recovery_count_limit_in, recovery_count_out, pin_live_level_out;
	logic [1:0] startup_target_state_in, startup_trigger_out;
	logic [1:0] pin_rise_irq_mask_in, pin_fall_irq_mask_in;
	logic [5:0] tbl [5] = '{6'h30, 6'h21, 6'h12, 6'h09, 6'h14};
	ped_pkg::ped_nvm_cfg_t nvm_cfg_in;
	ped_pkg::ped_irq_t irq_clear_in, irq_flag_out, svc;
	ped_pkg::ped_trigger_t trigger_out;
	ped_pkg::ped_sleep_sel_t sleep_sel_out;
	ped_pkg::ped_shutdown_t shutdown_out;
	int num_errors = 0, n_tests = 0, cycles = 0;
	ped_dispatch ped_dispatch_i (.*);
	ped_host_model ped_host_model_i (.ref_clk_in, .rstn_in,
		.flag_in(irq_flag_out), .svc_in(svc), .clear_out(irq_clear_in));
	//////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk_in = 0;
		forever #50 ref_clk_in = ~ref_clk_in;
	end
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end
	task step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#10;
	endtask : step
	task rst();
		rstn_in = 0;
		step(12);
		`CHK(shutdown_out, 4'hF)
		`CHK(irq_flag_out, 4'h0)
		rstn_in = 1;
		step(2);
	endtask : rst
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask : pulse
	task automatic want(input ped_pkg::ped_trigger_t t);
		seen = 0;
		repeat (8) begin
			step(1);
			if (trigger_out === t) seen = 1;
		end
	endtask : want
	task finish_test();
		$display("Errors %0d Checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	//////////////////////////////////////////////////////////////////////
	initial begin
		{internal_regulator_fault_in, main_clk_fault_in, recovery_event_in,
			analog_main_supply_uvlo_in, first_supply_detect_in,
			clk_detector_enable_in, clk_detector_missing_in, if_addr_error_in,
			primary_if_crc_enable_in, secondary_if_crc_enable_in} = '0;
		{wake_to_active_in, wake_to_mcu_only_in, sleep_ctrl_a_bit_in,
			sleep_ctrl_b_bit_in, sleep_ctrl_a_irq_mask_in,
			sleep_ctrl_b_irq_mask_in, first_supply_irq_mask_in, svc,
			clk_missing_irq_mask_in, addr_err_irq_mask_in} = '0;
		{sleep_ctrl_a_n_in, sleep_ctrl_b_n_in, rstn_in} = 3'h6;
		{pin_rise_irq_mask_in, pin_fall_irq_mask_in} = 4'h0;
		recovery_count_limit_in = 4'h2;
		startup_target_state_in = 2'h2;
		nvm_cfg_in = {ped_pkg::ACT_ORDERLY, ped_pkg::ACT_IRQ_ONLY};
		rst();
		first_supply_detect_in = 1;
		step(1);
		`CHK(trigger_out, ped_pkg::PED_TRG_STARTUP)
		`CHK(startup_trigger_out, 2'h2)
		`CHK({irq_flag_out.first_supply, irq_out}, 2'h3)
		{first_supply_irq_mask_in, first_supply_detect_in} = 2'h2;
		step(2);
		`CHK({irq_flag_out.first_supply, irq_out}, 2'h2)
		svc = 4'hF;
		step(3);
		`CHK(irq_flag_out, 4'h0)
		clk_detector_missing_in = 1;
		step(3);
		`CHK(irq_flag_out.clk_missing, 1'b0)
		{svc, clk_detector_enable_in} = {4'h0, 1'b1};
		step(2);
		`CHK({irq_flag_out.clk_missing, irq_out}, 2'h3)
		clk_missing_irq_mask_in = 1;
		step(2);
		`CHK(irq_out, 1'b0)
		{svc, clk_detector_enable_in} = {4'hF, 1'b0};
		step(3);
		for (int i = 0; i < 4; i++) begin
			{primary_if_crc_enable_in, secondary_if_crc_enable_in} = 2'(i);
			pulse(if_addr_error_in);
			`CHK(irq_flag_out.addr_err, (i == 3))
			step(3);
		end
		svc = 4'h0;
		wake_to_active_in = 1;
		want(ped_pkg::PED_TRG_ACTIVE);
		`CHK({seen, irq_flag_out.pin}, 2'h3)
		svc = 4'hF;
		wake_to_mcu_only_in = 1;
		want(ped_pkg::PED_TRG_MCU_ONLY);
		`CHK(seen, 1'b1)
		`CHK(pin_live_level_out[1:0], 2'h3)
		{svc, pin_rise_irq_mask_in, wake_to_active_in} = 7'h06;
		step(6);
		`CHK(irq_flag_out.pin, 1'b1)
		svc = 4'hF;
		step(3);
		{svc, wake_to_active_in} = 5'h01;
		step(6);
		`CHK(irq_flag_out.pin, 1'b0)
		for (int i = 0; i < 5; i++) begin
			{sleep_ctrl_a_n_in, sleep_ctrl_b_n_in, sleep_ctrl_a_irq_mask_in,
				sleep_ctrl_a_bit_in} = tbl[i][5:2];
			step(6);
			`CHK(sleep_sel_out, tbl[i][1:0])
			`CHK(pin_live_level_out[3:2], {tbl[i][4], tbl[i][5]})
			`CHK(trigger_out, (tbl[i][1:0] == 2'h0) ? ped_pkg::PED_TRG_NONE :
				ped_pkg::PED_TRG_SLEEP)
		end
		for (int k = 0; k < 3; k++) begin
			rst();
			recovery_count_limit_in = (k == 0) ? 4'h0 : 4'h2;
			nvm_cfg_in.recov_limit = (k == 2) ? ped_pkg::ACT_NONE :
				ped_pkg::ACT_ORDERLY;
			for (int n = 1; n < 18; n++) begin
				pulse(recovery_event_in);
				step(1);
				`CHK(recovery_count_out, 4'((n > 15) ? 15 : n))
			end
			step(20);
			`CHK(shutdown_out, (k == 1) ? 4'hB : 4'h0)
			`CHK(trigger_out, (k == 1) ? ped_pkg::PED_TRG_ORDERLY :
				ped_pkg::PED_TRG_NONE)
		end
		for (int i = 0; i < 3; i++) begin
			rst();
			{main_clk_fault_in, analog_main_supply_uvlo_in,
				internal_regulator_fault_in} = 3'(1 << i);
			step(2);
			`CHK({logic_reset_out, shutdown_out[3:1]}, 4'hF)
			{main_clk_fault_in, analog_main_supply_uvlo_in,
				internal_regulator_fault_in} = 3'h0;
			step(4);
			if (i < 2)
				`CHK(logic_reset_out, 1'b0)
			else
				`CHK({logic_reset_out, shutdown_out}, 5'h1E)
		end
		finish_test();
	end
endmodule : ped_dispatch_test
